// ==== verilog/pllsw_pkg.sv ====
// Constants for the PLL reference switchover controller
package pllsw_pkg;
   // Register byte offsets
   localparam logic [7:0] PLLSW_CTRL_OFS = 8'h00;
   localparam logic [7:0] PLLSW_RESYNC_OFS = 8'h04;
   localparam logic [7:0] PLLSW_STATUS_OFS = 8'h08;
   localparam logic [7:0] PLLSW_IRQ_STAT_OFS = 8'h0C;
   localparam logic [7:0] PLLSW_IRQ_MASK_OFS = 8'h10;
   // Control fields
   localparam int PLLSW_CTRL_AUTO_BIT = 0;
   localparam int PLLSW_CTRL_DLY_EN_BIT = 1;
   localparam int PLLSW_CTRL_DLY_LSB = 2;
   localparam int PLLSW_DLY_W = 5;
   localparam logic [31:0] PLLSW_CTRL_RST = 32'h0000_0001;
   // Resync length in ref_clk cycles
   localparam int PLLSW_RESYNC_W = 16;
   localparam logic [15:0] PLLSW_RESYNC_RST = 16'h0040;
   // Status fields
   localparam int PLLSW_ST_ACTIVE_BIT = 0;
   localparam int PLLSW_ST_FAIL0_BIT = 1;
   localparam int PLLSW_ST_FAIL1_BIT = 2;
   localparam int PLLSW_ST_COND_BIT = 3;
   localparam int PLLSW_ST_LOCK_BIT = 4;
   localparam int PLLSW_ST_BUSY_BIT = 5;
   // Interrupt events
   localparam int PLLSW_IRQ_W = 4;
   localparam int PLLSW_IRQ_DONE_BIT = 0;
   localparam int PLLSW_IRQ_FAIL0_BIT = 1;
   localparam int PLLSW_IRQ_FAIL1_BIT = 2;
   localparam int PLLSW_IRQ_LOCK_BIT = 3;
   // AXI responses
   localparam logic [1:0] PLLSW_RESP_OKAY = 2'h0;
   localparam logic [1:0] PLLSW_RESP_SLVERR = 2'h2;
   // Edge counter limit that marks a missing clock
   localparam logic [1:0] PLLSW_MISS_CNT = 2'h3;
   // Switchover sequencer states
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_DELAY = 5'b00010,
      ST_GATE = 5'b00100,
      ST_SWAP = 5'b01000,
      ST_RESYNC = 5'b10000
   } pllsw_state_t;
endpackage

// ==== verilog/pllsw_edge.sv ====
// Rising and falling edge detector for a sampled level
`timescale 1ns/10ps
module pllsw_edge (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic level,
   output logic rise,
   output logic fall
);
   logic prev_q;

   // Previous sample
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= 1'b0;
      end else if (ce) begin
         prev_q <= level;
      end
   end

   assign rise = ce & level & ~prev_q;
   assign fall = ce & ~level & prev_q;
endmodule

// ==== verilog/pllsw_top.sv ====
// PLL reference switchover controller with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// - Automatic failover and requested switching coexist
// - Request rising edge or automatic failure starts a switch
// - Glitch-free change, then resync before lock
// - Optional five-bit delay up to 31 incoming clock cycles
// - Request rising edge raises switch condition
// - Switchover follows the fixed state order, visiting DELAY only when the delay is enabled
// - Switch condition ORs active failure and request
// - Gate on outgoing fall, swap on incoming fall
module pllsw_top
   import pllsw_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic primary_reference_clock,
   input wire logic secondary_reference_clock,
   input wire logic switch_request,
   output logic active_clock,
   output logic ref_gate,
   output logic switch_condition,
   output logic ref_zero_fail_flag,
   output logic ref_one_fail_flag,
   output logic pll_locked,
   output logic irq,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import pllsw_pkg::*;

   pllsw_state_t state_q;
   logic r0_rise, r0_fall, r1_rise, r1_fall, req_rise;
   logic [1:0] cnt0_q, cnt1_q, cnt0_n, cnt1_n;
   logic fail0_d, fail1_d;
   logic [31:0] ctrl_q;
   logic [PLLSW_RESYNC_W-1:0] resync_len_q, resync_cnt_q;
   logic [PLLSW_IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
   logic [5:0] dly_cnt_q;
   logic act_fail, tgt_fail, trigger, out_fall, in_fall, in_rise;
   logic aw_held_q, w_held_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_go;
   logic [31:0] status_word;

   pllsw_edge u_edge_r0 (
      .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
      .level(primary_reference_clock), .rise(r0_rise), .fall(r0_fall)
   );
   pllsw_edge u_edge_r1 (
      .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
      .level(secondary_reference_clock), .rise(r1_rise), .fall(r1_fall)
   );
   pllsw_edge u_edge_req (
      .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
      .level(switch_request), .rise(req_rise), .fall()
   );

   // Edge counters: a count of three means the other clock stalled
   always_comb begin
      cnt0_n = cnt0_q + {1'b0, r0_rise};
      cnt1_n = cnt1_q + {1'b0, r1_rise};
      fail0_d = ref_zero_fail_flag;
      fail1_d = ref_one_fail_flag;
      if (r0_rise) begin
         fail0_d = 1'b0;
      end
      if (r1_rise) begin
         fail1_d = 1'b0;
      end
      if (cnt1_n == PLLSW_MISS_CNT) begin
         fail0_d = 1'b1;
         cnt1_n = 2'h0;
      end
      if (cnt0_n == PLLSW_MISS_CNT) begin
         fail1_d = 1'b1;
         cnt0_n = 2'h0;
      end
      if (cnt0_n != 2'h0 && cnt1_n != 2'h0) begin
         cnt0_n = 2'h0;
         cnt1_n = 2'h0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt0_q <= 2'h0;
         cnt1_q <= 2'h0;
         ref_zero_fail_flag <= 1'b0;
         ref_one_fail_flag <= 1'b0;
      end else if (ce) begin
         cnt0_q <= cnt0_n;
         cnt1_q <= cnt1_n;
         ref_zero_fail_flag <= fail0_d;
         ref_one_fail_flag <= fail1_d;
      end
   end

   assign act_fail = active_clock ? ref_one_fail_flag : ref_zero_fail_flag;
   assign tgt_fail = active_clock ? ref_zero_fail_flag : ref_one_fail_flag;
   assign out_fall = active_clock ? r1_fall : r0_fall;
   assign in_fall = active_clock ? r0_fall : r1_fall;
   assign in_rise = active_clock ? r0_rise : r1_rise;
   assign trigger = ~tgt_fail & (req_rise | (ctrl_q[PLLSW_CTRL_AUTO_BIT] & act_fail));

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         switch_condition <= 1'b0;
      end else if (ce) begin
         switch_condition <= (~active_clock & ref_zero_fail_flag)
            | (active_clock & ref_one_fail_flag) | switch_request;
      end
   end

   // Switchover sequencer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         active_clock <= 1'b0;
         ref_gate <= 1'b1;
         pll_locked <= 1'b1;
         dly_cnt_q <= 6'h00;
         resync_cnt_q <= '0;
      end else if (ce) begin
         unique case (state_q)
            ST_IDLE: begin
               dly_cnt_q <= 6'h00;
               if (trigger) begin
                  state_q <= ctrl_q[PLLSW_CTRL_DLY_EN_BIT] ? ST_DELAY : ST_GATE;
               end
            end
            ST_DELAY: begin
               if (dly_cnt_q == {1'b0, ctrl_q[PLLSW_CTRL_DLY_LSB +: PLLSW_DLY_W]}) begin
                  state_q <= ST_GATE;
               end else if (in_rise) begin
                  dly_cnt_q <= dly_cnt_q + 6'h01;
               end
            end
            ST_GATE: begin
               // Gate on outgoing fall or stall
               if (out_fall || act_fail) begin
                  ref_gate <= 1'b0;
                  state_q <= ST_SWAP;
               end
            end
            ST_SWAP: begin
               if (in_fall) begin
                  active_clock <= ~active_clock;
                  ref_gate <= 1'b1;
                  pll_locked <= 1'b0;
                  resync_cnt_q <= '0;
                  state_q <= ST_RESYNC;
               end
            end
            ST_RESYNC: begin
               if (resync_cnt_q >= resync_len_q) begin
                  pll_locked <= 1'b1;
                  state_q <= ST_IDLE;
               end else begin
                  resync_cnt_q <= resync_cnt_q + 16'h0001;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Interrupt events
   always_comb begin
      irq_set = '0;
      irq_set[PLLSW_IRQ_DONE_BIT] = (state_q == ST_SWAP) & in_fall;
      irq_set[PLLSW_IRQ_FAIL0_BIT] = fail0_d & ~ref_zero_fail_flag & ce;
      irq_set[PLLSW_IRQ_FAIL1_BIT] = fail1_d & ~ref_one_fail_flag & ce;
      irq_set[PLLSW_IRQ_LOCK_BIT] = ce & (state_q == ST_RESYNC)
         & (resync_cnt_q >= resync_len_q);
   end

   assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;

   // Write channel capture
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PLLSW_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_q == PLLSW_CTRL_OFS || aw_addr_q == PLLSW_RESYNC_OFS
               || aw_addr_q == PLLSW_STATUS_OFS || aw_addr_q == PLLSW_IRQ_STAT_OFS
               || aw_addr_q == PLLSW_IRQ_MASK_OFS) ? PLLSW_RESP_OKAY : PLLSW_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;

   // Control registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= PLLSW_CTRL_RST;
         resync_len_q <= PLLSW_RESYNC_RST;
         irq_mask_q <= '0;
      end else if (ce && wr_go) begin
         for (int i = 0; i < 4; i++) begin
            if (w_strb_q[i] && aw_addr_q == PLLSW_CTRL_OFS) begin
               ctrl_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
            end
         end
         if (aw_addr_q == PLLSW_RESYNC_OFS) begin
            if (w_strb_q[0]) begin
               resync_len_q[7:0] <= w_data_q[7:0];
            end
            if (w_strb_q[1]) begin
               resync_len_q[15:8] <= w_data_q[15:8];
            end
         end
         if (aw_addr_q == PLLSW_IRQ_MASK_OFS && w_strb_q[0]) begin
            irq_mask_q <= w_data_q[PLLSW_IRQ_W-1:0];
         end
      end
   end

   // Sticky status, write one to clear, set wins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_q <= '0;
      end else if (ce) begin
         if (wr_go && aw_addr_q == PLLSW_IRQ_STAT_OFS && w_strb_q[0]) begin
            irq_stat_q <= (irq_stat_q & ~w_data_q[PLLSW_IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[PLLSW_ST_ACTIVE_BIT] = active_clock;
      status_word[PLLSW_ST_FAIL0_BIT] = ref_zero_fail_flag;
      status_word[PLLSW_ST_FAIL1_BIT] = ref_one_fail_flag;
      status_word[PLLSW_ST_COND_BIT] = switch_condition;
      status_word[PLLSW_ST_LOCK_BIT] = pll_locked;
      status_word[PLLSW_ST_BUSY_BIT] = (state_q != ST_IDLE);
   end

   // Read channel
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= PLLSW_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= PLLSW_RESP_OKAY;
            unique case (s_axi_araddr)
               PLLSW_CTRL_OFS: s_axi_rdata <= ctrl_q;
               PLLSW_RESYNC_OFS: s_axi_rdata <= {16'h0000, resync_len_q};
               PLLSW_STATUS_OFS: s_axi_rdata <= status_word;
               PLLSW_IRQ_STAT_OFS: s_axi_rdata <= {28'h0000000, irq_stat_q};
               PLLSW_IRQ_MASK_OFS: s_axi_rdata <= {28'h0000000, irq_mask_q};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= PLLSW_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   assign s_axi_arready = ~s_axi_rvalid;
endmodule

// ==== verif/pllsw_top_asserts.sv ====
// Port checker for the switchover controller
`timescale 1ns/10ps
module pllsw_top_asserts (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic primary_reference_clock,
   input wire logic secondary_reference_clock,
   input wire logic switch_request,
   input wire logic active_clock,
   input wire logic ref_gate,
   input wire logic switch_condition,
   input wire logic ref_zero_fail_flag,
   input wire logic ref_one_fail_flag,
   input wire logic pll_locked
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   cond_or_a: assert property (
      1'b1 |=> switch_condition == ((!$past(active_clock) && $past(ref_zero_fail_flag))
         || ($past(active_clock) && $past(ref_one_fail_flag)) || $past(switch_request)))
      else $error("switch condition not the OR of its terms");
   cond_rise_a: assert property (
      $rose(switch_request) |=> switch_condition)
      else $error("switch condition missed request edge");
   gate_fall_a: assert property (
      $fell(ref_gate) |-> (active_clock ? !secondary_reference_clock : !primary_reference_clock))
      else $error("gate closed off the outgoing low phase");
   swap_fall_a: assert property (
      $changed(active_clock) |-> (active_clock ? !secondary_reference_clock
         : !primary_reference_clock))
      else $error("swap off the incoming low phase");
   swap_glitch_a: assert property (
      $changed(active_clock) |-> ref_gate && !pll_locked && !$past(ref_gate))
      else $error("swap without prior gating");
   relock_time_a: assert property (
      $fell(pll_locked) |-> !pll_locked [*5] ##[1:2] pll_locked)
      else $error("resync length wrong");
   single_swap_a: assert property (
      $changed(active_clock) |=> $stable(active_clock) [*6])
      else $error("second swap without new request");
   auto_fail_a: assert property (
      $rose(ref_zero_fail_flag) && !active_clock && !ref_one_fail_flag
         |-> ##[1:400] active_clock)
      else $error("no automatic failover");
endmodule
bind pllsw_top pllsw_top_asserts i_pllsw_top_asserts (.ref_clk, .rst_n,
   .primary_reference_clock, .secondary_reference_clock, .switch_request, .active_clock,
   .ref_gate, .switch_condition, .ref_zero_fail_flag, .ref_one_fail_flag, .pll_locked);

// ==== verif/pllsw_user.sv ====
// Fabric control logic that requests switchovers and sequences enables
`timescale 1ns/10ps
module pllsw_user #(
   parameter int HOLD = 32
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic hold_long,
   input wire logic ext_enable,
   input wire logic switch_condition,
   input wire logic pll_locked,
   input wire logic ref_zero_failed,
   input wire logic ref_one_failed,
   output logic switch_request,
   output logic pll_output_enable,
   output logic downstream_reset,
   output logic pll_async_reset,
   output logic phase_detector_enable,
   output logic system_enable,
   output logic data_select
);
   logic [1:0] cond_q;
   logic [1:0] lock_q;
   logic [1:0] fail_q;
   logic data_sel_q;
   int cnt_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_q <= 2'h0;
         lock_q <= 2'h0;
         fail_q <= 2'h0;
      end else begin
         cond_q <= {cond_q[0], switch_condition};
         lock_q <= {lock_q[0], pll_locked};
         fail_q <= {fail_q[0], ref_zero_failed | ref_one_failed};
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 0;
         switch_request <= 1'b0;
         data_sel_q <= 1'b0;
      end else if (go && cnt_q == 0) begin
         cnt_q <= hold_long ? HOLD * 8 : HOLD;
         switch_request <= 1'b1;
         data_sel_q <= !data_sel_q;
      end else if (cnt_q > 0) begin
         cnt_q <= cnt_q - 1;
         switch_request <= cnt_q > 1;
      end
   end
   assign data_select = data_sel_q;
   assign pll_output_enable = !switch_request && lock_q[1] && ext_enable;
   assign downstream_reset = cond_q[1] || !lock_q[1];
   assign pll_async_reset = lock_q[1] && !lock_q[0];
   assign phase_detector_enable = !fail_q[1];
   assign system_enable = !cond_q[1] && lock_q[1];
endmodule

// ==== verif/pllsw_top_tb_top.sv ====
// Testbench for the switchover controller
`timescale 1ns/10ps
module pllsw_top_tb_top;
   import pllsw_pkg::*;
   logic ref_clk = 0, rst_n = 0, prim_run = 1, go = 0, hold_long = 0;
   logic primary_reference_clock = 0, secondary_reference_clock = 0, switch_request;
   logic active_clock, ref_gate, switch_condition, ref_zero_fail_flag, pll_locked, irq;
   logic ref_one_fail_flag, pll_output_enable, downstream_reset, pll_async_reset;
   logic phase_detector_enable, system_enable, data_select;
   logic [1:0] pc = 0, s_axi_bresp, s_axi_rresp;
   logic [2:0] sc = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   int errors = 0, n_checks = 0, n, n_ar = 0;
   always #25 ref_clk = !ref_clk;
   always @(posedge ref_clk) begin
      if (pll_async_reset === 1'b1) n_ar <= n_ar + 1;
   end
   always @(posedge ref_clk) begin
      pc <= pc + 2'h1;
      sc <= (sc == 3'h4) ? 3'h0 : sc + 3'h1;
      if (pc == 2'h3) primary_reference_clock <= prim_run && !primary_reference_clock;
      if (sc == 3'h4) secondary_reference_clock <= !secondary_reference_clock;
   end
   pllsw_top i_pllsw_top (.ref_clk, .rst_n, .ce(1'b1), .primary_reference_clock,
      .secondary_reference_clock, .switch_request, .active_clock, .ref_gate,
      .switch_condition, .ref_zero_fail_flag, .ref_one_fail_flag, .pll_locked, .irq,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   pllsw_user i_pllsw_user (.ref_clk, .rst_n, .go, .hold_long, .ext_enable(1'b1),
      .switch_condition, .pll_locked, .switch_request, .pll_output_enable,
      .downstream_reset, .ref_zero_failed(ref_zero_fail_flag),
      .ref_one_failed(ref_one_fail_flag), .pll_async_reset, .phase_detector_enable,
      .system_enable, .data_select);
   task summarize;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task tmo(input int k);
      if (k >= 2000) begin
         chk("wait done", 1, 0);
         summarize();
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      k = 0;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         k++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && k < 2000);
      s_axi_bready <= 1'b0;
      tmo(k);
      chk("bresp", er, s_axi_bresp);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
         input logic [1:0] er);
      int k;
      k = 0;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         k++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && k < 2000);
      s_axi_rready <= 1'b0;
      tmo(k);
      chk("rdata", e, s_axi_rdata & m);
      chk("rresp", er, s_axi_rresp);
   endtask
   function logic sel(input int s);
      case (s)
         0: return pll_locked;
         1: return switch_request;
         2: return active_clock;
         default: return ref_zero_fail_flag;
      endcase
   endfunction
   task wt(input int s, input logic v, output int k);
      k = 0;
      while (sel(s) !== v && k < 2000) begin
         @(negedge ref_clk);
         k++;
      end
      tmo(k);
   endtask
   task sw(input logic hl);
      @(posedge ref_clk);
      go <= 1'b1;
      hold_long <= hl;
      @(posedge ref_clk);
      go <= 1'b0;
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(PLLSW_CTRL_OFS, PLLSW_CTRL_RST, 32'hFFFFFFFF, PLLSW_RESP_OKAY);
      rd(PLLSW_RESYNC_OFS, 32'h40, 32'hFFFFFFFF, PLLSW_RESP_OKAY);
      rd(PLLSW_IRQ_MASK_OFS, 32'h0, 32'hFFFFFFFF, PLLSW_RESP_OKAY);
      rd(8'h14, 32'h0, 32'hFFFFFFFF, PLLSW_RESP_SLVERR);
      wr(8'h14, 32'h1, PLLSW_RESP_SLVERR);
      wr(PLLSW_STATUS_OFS, 32'h3F, PLLSW_RESP_OKAY);
      rd(PLLSW_STATUS_OFS, 32'h10, 32'h3F, PLLSW_RESP_OKAY);
      wr(PLLSW_RESYNC_OFS, 32'h4, PLLSW_RESP_OKAY);
      wr(PLLSW_IRQ_MASK_OFS, 32'h3, PLLSW_RESP_OKAY);
      sw(1'b1);
      wt(0, 1'b0, n);
      chk("swap latency", 1, n < 40);
      chk("output enable", 0, pll_output_enable);
      chk("downstream reset", 1, downstream_reset);
      chk("system enable", 0, system_enable);
      wt(0, 1'b1, n);
      chk("resync", 1, n > 3 && n < 7);
      chk("active", 1, active_clock);
      chk("channel", 1, data_select);
      chk("irq", 1, irq);
      wr(PLLSW_IRQ_STAT_OFS, 32'hF, PLLSW_RESP_OKAY);
      @(negedge ref_clk);
      chk("irq", 0, irq);
      wt(1, 1'b0, n);
      repeat (50) @(negedge ref_clk);
      chk("active held", 1, active_clock);
      chk("output enable", 1, pll_output_enable);
      chk("downstream reset", 0, downstream_reset);
      chk("system enable", 1, system_enable);
      wr(PLLSW_CTRL_OFS, 32'h7F, PLLSW_RESP_OKAY);
      sw(1'b0);
      wt(0, 1'b0, n);
      chk("delay", 1, n > 239);
      wt(0, 1'b1, n);
      chk("active", 0, active_clock);
      wr(PLLSW_CTRL_OFS, 32'h1, PLLSW_RESP_OKAY);
      @(posedge ref_clk);
      prim_run <= 1'b0;
      wt(2, 1'b1, n);
      wt(0, 1'b1, n);
      chk("fail0", 1, ref_zero_fail_flag);
      chk("fail1", 0, ref_one_fail_flag);
      chk("condition", 0, switch_condition);
      chk("phase detector", 0, phase_detector_enable);
      rd(PLLSW_IRQ_STAT_OFS, 32'h2, 32'h2, PLLSW_RESP_OKAY);
      @(posedge ref_clk);
      prim_run <= 1'b1;
      wt(3, 1'b0, n);
      sw(1'b0);
      wt(0, 1'b0, n);
      wt(0, 1'b1, n);
      chk("active back", 0, active_clock);
      chk("upstream resets", 4, n_ar);
      summarize();
   end
endmodule
